/* File: src/fat_pkg.sv */
// constants for the frame arrival timing monitor
// assumes a 250 MHz core clock and a 3.84 Mchip/s air rate
package fat_pkg;

  // clock and chip rates
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned CHIP_KHZ = 3840;

  // base frame counter: one tick is 125 us
  localparam int unsigned TICK_NS = 125000;
  localparam int unsigned CHIPS_PER_TICK = TICK_NS * CHIP_KHZ / 1000000;
  localparam int unsigned TICKS_PER_MS = 1000000 / TICK_NS;
  localparam int unsigned FRAME_MS = 10;
  localparam int unsigned TICKS_PER_FRAME = FRAME_MS * TICKS_PER_MS;
  localparam int unsigned BASE_FRAMES = 4096;
  localparam int unsigned BASE_TICKS = BASE_FRAMES * TICKS_PER_FRAME;
  localparam int unsigned BASE_W = 19;
  localparam int unsigned FRAME_NUM_W = 12;

  // connection frame number length and window limits
  localparam int unsigned CONN_FRAMES = 256;
  localparam int unsigned CONN_MS = CONN_FRAMES * FRAME_MS;
  localparam logic [11:0] WIN_START_MAX_MS = 12'(CONN_MS / 2 - 1);
  localparam logic [11:0] WIN_END_MAX_MS = 12'(CONN_MS - 1);
  localparam int OFFSET_POS_MAX = int'(CONN_MS * TICKS_PER_MS / 2) - 1;
  localparam int OFFSET_NEG_MIN = -int'(CONN_MS * TICKS_PER_MS / 2);

  // per-cell delay in 256-chip steps
  localparam int unsigned CELL_STEP_CHIPS = 256;
  localparam logic [3:0] CELL_DELAY_MAX = 4'h9;

  // secondary common control channel offsets in frames (0,10,20,40 ms)
  localparam logic [11:0] SCC_OFF_0 = 12'h000;
  localparam logic [11:0] SCC_OFF_1 = 12'h001;
  localparam logic [11:0] SCC_OFF_2 = 12'h002;
  localparam logic [11:0] SCC_OFF_3 = 12'h004;

  // register offsets
  localparam logic [7:0] REG_WIN_START = 8'h00;
  localparam logic [7:0] REG_WIN_END = 8'h04;
  localparam logic [7:0] REG_PROC_TIME = 8'h08;
  localparam logic [7:0] REG_CELL_CFG = 8'h0c;
  localparam logic [7:0] REG_ARRIVAL = 8'h10;
  localparam logic [7:0] REG_CTRL_STAMP = 8'h14;
  localparam logic [7:0] REG_RX_STAMP = 8'h18;
  localparam logic [7:0] REG_TX_STAMP = 8'h1c;
  localparam logic [7:0] REG_BASE_COUNT = 8'h20;
  localparam logic [7:0] REG_FRAME_NUM = 8'h24;

  // field positions
  localparam int unsigned CELL_DELAY_LSB = 0;
  localparam int unsigned CELL_SCC_LSB = 4;
  localparam int unsigned ARR_EARLY_BIT = 16;
  localparam int unsigned ARR_LATE_BIT = 17;
  localparam int unsigned ARR_DISCARD_BIT = 18;

  // reset values
  localparam logic [11:0] WIN_START_RST = 12'h000;
  localparam logic [11:0] WIN_END_RST = 12'h000;
  localparam logic [18:0] PROC_TIME_RST = 19'h00008;
  localparam logic [3:0] CELL_DELAY_RST = 4'h0;
  localparam logic [1:0] SCC_SEL_RST = 2'h0;

  typedef enum logic [1:0] {
    FAT_SYNC_IDLE = 2'b01,
    FAT_SYNC_REPLY = 2'b10
  } fat_sync_state_e;

endpackage

/* File: src/fat_base_counter.sv */
// free-running base frame counter with chip and 125 us tick timing
// assumes the core clock of fat_pkg; chips come from a phase accumulator
`timescale 1ns/1ps
module fat_base_counter #(
  parameter int TICK_CHIPS = fat_pkg::CHIPS_PER_TICK
) (
  input wire logic core_clk,
  input wire logic arst_n,
  output logic chipStrobe,
  output logic [15:0] chipInFrame,
  output logic [18:0] baseFrameCounter
);

  localparam logic [17:0] ACC_ADD = 18'(fat_pkg::CHIP_KHZ);
  localparam logic [17:0] ACC_SUB = 18'(fat_pkg::CLK_KHZ - fat_pkg::CHIP_KHZ);
  localparam logic [15:0] TICK_LAST = 16'(TICK_CHIPS - 1);
  localparam logic [15:0] FRAME_LAST =
    16'(TICK_CHIPS * fat_pkg::TICKS_PER_FRAME - 1);
  localparam logic [18:0] BASE_LAST = 19'(fat_pkg::BASE_TICKS - 1);

  logic [17:0] phaseAcc;
  logic [15:0] chipInTick;
  wire chipHit = phaseAcc >= ACC_SUB;
  wire tickWrap = chipHit && (chipInTick == TICK_LAST);
  wire [17:0] next_phaseAcc = chipHit ? phaseAcc - ACC_SUB
                                      : phaseAcc + ACC_ADD;
  wire [15:0] next_chipInTick = tickWrap ? 16'h0000 : chipInTick + 16'h0001;
  wire [15:0] next_chipInFrame =
    (chipInFrame == FRAME_LAST) ? 16'h0000 : chipInFrame + 16'h0001;
  wire [18:0] next_baseFrameCounter =
    (baseFrameCounter == BASE_LAST) ? 19'h00000
                                   : baseFrameCounter + 19'h00001;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phaseAcc <= 18'h00000;
      chipStrobe <= 1'b0;
      chipInTick <= 16'h0000;
      chipInFrame <= 16'h0000;
      baseFrameCounter <= 19'h00000;
    end
    else
    begin
      phaseAcc <= next_phaseAcc;
      chipStrobe <= chipHit;
      if (chipHit)
      begin
        chipInTick <= next_chipInTick;
        chipInFrame <= next_chipInFrame;
      end
      if (tickWrap)
        baseFrameCounter <= next_baseFrameCounter; // RULE18
    end
  end

  AST_BASE_STEP: assert property (@(posedge core_clk) // RULE18
    disable iff (!arst_n)
    $changed(baseFrameCounter) |-> baseFrameCounter ==
      (($past(baseFrameCounter) == BASE_LAST) ? 19'h00000
        : $past(baseFrameCounter) + 19'h00001))
    else $error("base frame counter stepped wrongly");

endmodule // fat_base_counter

/* File: src/fat_monitor.sv */
// frame arrival timing monitor: arrival window check, node sync stamps,
// per-cell frame timing behind the base frame counter
// assumes transport-side strobes come from logic on core_clk
// Summary of operation
// RULE1: early frame requests timing adjustment
// RULE2: late frame requests timing adjustment
// RULE3: window start held in 1 ms, half length
// RULE4: window end held in 1 ms, full length
// RULE5: frames after latest point are discarded
// RULE6: late but in time: process and adjust
// RULE7: latest point is processing time before send
// RULE8: offset is window end minus arrival
// RULE9: offset clamped to half connection length, both signs
// RULE10: controller stamps its send time
// RULE11: receive stamp taken on sync arrival
// RULE12: send stamp taken when reply handed over
// RULE13: controller keeps its own receive stamp
// RULE14: cell frames lag base counter, 256-chip steps
// RULE15: cell delay starts sync, pilot, scrambling
// RULE16: secondary channel offset 0/10/20/40 ms
// RULE17: every sync frame gets one reply; one arriving while a reply is pending gets none here
// RULE18: one free-running 125 us base counter
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module fat_monitor #(
  parameter int TICK_CHIPS = fat_pkg::CHIPS_PER_TICK
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic dataFrameValid,
  input wire logic [18:0] dataFrameDue,
  output logic frameAccept,
  output logic frameDiscard,
  output logic timingAdjReq,
  output logic [15:0] arrivalOffset,
  input wire logic syncDlValid,
  input wire logic [18:0] syncDlStamp,
  output logic syncUlValid,
  input wire logic syncUlReady,
  output logic [18:0] syncUlCtrlStamp,
  output logic [18:0] syncUlRxStamp,
  output logic [18:0] syncUlTxStamp,
  output logic cellFrameStart,
  output logic [11:0] systemFrameNumber,
  output logic [11:0] sccpchFrameNumber,
  output logic [18:0] baseFrameCounter
);

  default clocking chkClk @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  localparam logic [19:0] BASE_TICKS20 = 20'(fat_pkg::BASE_TICKS);
  localparam logic [18:0] BASE_HALF = 19'(fat_pkg::BASE_TICKS / 2);

  // modular difference on the base counter ring
  function automatic logic [18:0] modSub(input logic [18:0] a,
                                         input logic [18:0] b);
    logic [19:0] d;
    d = {1'b0, a} - {1'b0, b};
    if (a < b)
      d = d + BASE_TICKS20;
    return d[18:0];
  endfunction

  // signed distance a - b, nearest way round the ring
  function automatic logic signed [19:0] wrapDiff(input logic [18:0] a,
                                                  input logic [18:0] b);
    logic [18:0] m;
    m = modSub(a, b);
    if (m >= BASE_HALF)
      return signed'({1'b0, m}) - signed'(BASE_TICKS20);
    return signed'({1'b0, m});
  endfunction

  function automatic logic [18:0] msToTicks(input logic [11:0] ms);
    return 19'(ms) * 19'(fat_pkg::TICKS_PER_MS);
  endfunction

  function automatic logic [11:0] clampMs(input logic [31:0] v,
                                          input logic [11:0] lim);
    return (v > 32'(lim)) ? lim : v[11:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // base frame counter

  logic chipStrobe;
  logic [15:0] chipInFrame;

  fat_base_counter #(
    .TICK_CHIPS(TICK_CHIPS)
  ) u_counter (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .chipStrobe(chipStrobe),
    .chipInFrame(chipInFrame),
    .baseFrameCounter(baseFrameCounter)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [11:0] winStartMs;
  logic [11:0] winEndMs;
  logic [18:0] procTicks;
  logic [3:0] cellDelay;
  logic [1:0] sccSel;
  logic arrEarly;
  logic arrLate;
  logic arrDiscard;
  logic [18:0] txStampHeld;

  wire wrStart = regWr && (regAddr == fat_pkg::REG_WIN_START);
  wire wrEnd = regWr && (regAddr == fat_pkg::REG_WIN_END);
  wire wrProc = regWr && (regAddr == fat_pkg::REG_PROC_TIME);
  wire wrCell = regWr && (regAddr == fat_pkg::REG_CELL_CFG);
  wire [3:0] wrDelay = regWdata[fat_pkg::CELL_DELAY_LSB +: 4];
  wire [3:0] next_cellDelay =
    (wrDelay > fat_pkg::CELL_DELAY_MAX) ? fat_pkg::CELL_DELAY_MAX : wrDelay;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      winStartMs <= fat_pkg::WIN_START_RST;
      winEndMs <= fat_pkg::WIN_END_RST;
      procTicks <= fat_pkg::PROC_TIME_RST;
      cellDelay <= fat_pkg::CELL_DELAY_RST;
      sccSel <= fat_pkg::SCC_SEL_RST;
    end
    else
    begin
      if (wrStart)
        winStartMs <= clampMs(regWdata, fat_pkg::WIN_START_MAX_MS); // RULE3
      if (wrEnd)
        winEndMs <= clampMs(regWdata, fat_pkg::WIN_END_MAX_MS); // RULE4
      if (wrProc)
        procTicks <= regWdata[18:0]; // RULE7
      if (wrCell)
      begin
        cellDelay <= next_cellDelay; // RULE14
        sccSel <= regWdata[fat_pkg::CELL_SCC_LSB +: 2]; // RULE16
      end
    end
  end

  wire [31:0] arrWord = {13'h0000, arrDiscard, arrLate, arrEarly,
                         arrivalOffset};
  wire [31:0] next_regRdata =
    !regRd ? 32'h00000000 :
    (regAddr == fat_pkg::REG_WIN_START) ? {20'h00000, winStartMs} :
    (regAddr == fat_pkg::REG_WIN_END) ? {20'h00000, winEndMs} :
    (regAddr == fat_pkg::REG_PROC_TIME) ? {13'h0000, procTicks} :
    (regAddr == fat_pkg::REG_CELL_CFG) ? {26'h0000000, sccSel, cellDelay} :
    (regAddr == fat_pkg::REG_ARRIVAL) ? arrWord :
    (regAddr == fat_pkg::REG_CTRL_STAMP) ? {13'h0000, syncUlCtrlStamp} :
    (regAddr == fat_pkg::REG_RX_STAMP) ? {13'h0000, syncUlRxStamp} :
    (regAddr == fat_pkg::REG_TX_STAMP) ? {13'h0000, txStampHeld} :
    (regAddr == fat_pkg::REG_BASE_COUNT) ? {13'h0000, baseFrameCounter} :
    (regAddr == fat_pkg::REG_FRAME_NUM) ? {20'h00000, systemFrameNumber} :
    32'h00000000;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      regRdata <= 32'h00000000;
    else
      regRdata <= next_regRdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // data frame arrival check

  wire [18:0] latestPoint = modSub(dataFrameDue, procTicks); // RULE7
  wire [18:0] windowEnd = modSub(latestPoint, msToTicks(winEndMs)); // RULE4
  wire signed [19:0] offsetRaw = wrapDiff(windowEnd, baseFrameCounter); // RULE8
  wire signed [19:0] latestMargin = wrapDiff(latestPoint, baseFrameCounter);
  wire signed [19:0] startDist = signed'({1'b0, msToTicks(winStartMs)});
  wire isDiscard = latestMargin < 0; // RULE5
  wire isLate = offsetRaw < 0; // RULE2
  wire isEarly = offsetRaw > startDist; // RULE1 RULE3
  wire signed [19:0] offsetClamped =
    (offsetRaw > 20'(fat_pkg::OFFSET_POS_MAX)) ?
      20'(fat_pkg::OFFSET_POS_MAX) :
    (offsetRaw < 20'(fat_pkg::OFFSET_NEG_MIN)) ?
      20'(fat_pkg::OFFSET_NEG_MIN) : offsetRaw; // RULE9

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      frameAccept <= 1'b0;
      frameDiscard <= 1'b0;
      timingAdjReq <= 1'b0;
    end
    else
    begin
      frameAccept <= dataFrameValid && !isDiscard; // RULE5 RULE6
      frameDiscard <= dataFrameValid && isDiscard; // RULE5
      timingAdjReq <= dataFrameValid && (isEarly || isLate); // RULE1 RULE2
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      arrivalOffset <= 16'h0000;
      arrEarly <= 1'b0;
      arrLate <= 1'b0;
      arrDiscard <= 1'b0;
    end
    else if (dataFrameValid)
    begin
      arrivalOffset <= offsetClamped[15:0]; // RULE8 RULE9
      arrEarly <= isEarly;
      arrLate <= isLate;
      arrDiscard <= isDiscard;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // node synchronisation reply

  fat_pkg::fat_sync_state_e syncState;
  fat_pkg::fat_sync_state_e next_syncState;

  always_comb
  begin
    next_syncState = syncState;
    case (syncState)
      fat_pkg::FAT_SYNC_IDLE:
        if (syncDlValid)
          next_syncState = fat_pkg::FAT_SYNC_REPLY; // RULE17
      fat_pkg::FAT_SYNC_REPLY:
        if (syncUlReady)
          next_syncState = fat_pkg::FAT_SYNC_IDLE;
      default:
        next_syncState = fat_pkg::FAT_SYNC_IDLE;
    endcase
  end

  wire syncTake = (syncState == fat_pkg::FAT_SYNC_IDLE) && syncDlValid;
  wire syncHand = syncUlValid && syncUlReady;
  assign syncUlValid = syncState == fat_pkg::FAT_SYNC_REPLY;
  // send stamp is the live counter, so it is exact at hand-over
  assign syncUlTxStamp = baseFrameCounter; // RULE12

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      syncState <= fat_pkg::FAT_SYNC_IDLE;
    else
      syncState <= next_syncState;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncUlCtrlStamp <= 19'h00000;
      syncUlRxStamp <= 19'h00000;
      txStampHeld <= 19'h00000;
    end
    else
    begin
      if (syncTake)
      begin
        syncUlCtrlStamp <= syncDlStamp; // RULE10 RULE17
        syncUlRxStamp <= baseFrameCounter; // RULE11
      end
      if (syncHand)
        txStampHeld <= baseFrameCounter; // RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cell frame timing

  wire [15:0] cellOffsetChips =
    16'(cellDelay) * 16'(fat_pkg::CELL_STEP_CHIPS); // RULE14
  wire cellHit = chipStrobe && (chipInFrame == cellOffsetChips); // RULE15
  wire [11:0] sccOffset =
    (sccSel == 2'h0) ? fat_pkg::SCC_OFF_0 :
    (sccSel == 2'h1) ? fat_pkg::SCC_OFF_1 :
    (sccSel == 2'h2) ? fat_pkg::SCC_OFF_2 : fat_pkg::SCC_OFF_3;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cellFrameStart <= 1'b0;
      systemFrameNumber <= 12'h000;
    end
    else
    begin
      cellFrameStart <= cellHit; // RULE15
      if (cellHit)
        systemFrameNumber <= systemFrameNumber + 12'h001; // RULE14
    end
  end

  assign sccpchFrameNumber = systemFrameNumber - sccOffset; // RULE16

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_EARLY_ADJ: assert property ( // RULE1
    dataFrameValid && isEarly |=> timingAdjReq && frameAccept)
    else $error("early frame without adjustment");
  AST_LATE_ADJ: assert property ( // RULE2
    dataFrameValid && isLate |=> timingAdjReq && arrLate)
    else $error("late frame without adjustment");
  AST_START_RANGE: assert property ( // RULE3
    winStartMs <= fat_pkg::WIN_START_MAX_MS)
    else $error("window start out of range");
  AST_END_WRITE: assert property ( // RULE4
    wrEnd |=> winEndMs ==
      (($past(regWdata) > 32'(fat_pkg::WIN_END_MAX_MS)) ?
        fat_pkg::WIN_END_MAX_MS : $past(regWdata[11:0])))
    else $error("window end write not held");
  AST_DISCARD: assert property ( // RULE5
    dataFrameValid && isDiscard |=> frameDiscard && !frameAccept)
    else $error("frame past latest point not discarded");
  AST_LATE_KEPT: assert property ( // RULE6
    dataFrameValid && isLate && !isDiscard |=> frameAccept && timingAdjReq)
    else $error("late frame in time not processed");
  AST_OFFSET_SIGN: assert property ( // RULE8
    dataFrameValid |=> arrivalOffset[15] == arrLate)
    else $error("arrival offset sign wrong");
  AST_OFFSET_RANGE: assert property ( // RULE9
    signed'(arrivalOffset) <= 16'(fat_pkg::OFFSET_POS_MAX) &&
    signed'(arrivalOffset) >= 16'(fat_pkg::OFFSET_NEG_MIN))
    else $error("arrival offset out of range");
  AST_RX_STAMP: assert property ( // RULE11
    syncTake |=> syncUlRxStamp == $past(baseFrameCounter) &&
      syncUlCtrlStamp == $past(syncDlStamp))
    else $error("receive stamp not captured");
  AST_TX_STAMP: assert property ( // RULE12
    syncHand |=> txStampHeld == $past(syncUlTxStamp) && !syncUlValid)
    else $error("send stamp not captured");
  AST_REPLY: assert property ( // RULE17
    syncTake |=> syncUlValid)
    else $error("sync frame not answered");
  AST_CELL_START: assert property ( // RULE14
    cellFrameStart |-> $past(chipInFrame) == $past(cellOffsetChips))
    else $error("cell frame start misplaced");
  AST_SCC_OFFSET: assert property ( // RULE16
    systemFrameNumber - sccpchFrameNumber ==
      ((sccSel == 2'h3) ? fat_pkg::SCC_OFF_3 : 12'(sccSel)))
    else $error("secondary channel offset wrong");

  COV_EARLY: cover property (dataFrameValid && isEarly);
  COV_LATE_KEPT: cover property (dataFrameValid && isLate && !isDiscard);
  COV_DISCARD: cover property (frameDiscard);
  COV_SYNC: cover property (syncTake ##[1:8] syncHand);

endmodule // fat_monitor

/* File: testbench/fat_ctrl_model.sv */
// controller-side model of the node sync exchange
// assumes one caller of send_sync at a time, after reset release
`timescale 1ns/1ps
module fat_ctrl_model (
  input wire logic core_clk,
  input wire logic syncUlValid,
  input wire logic [18:0] syncUlCtrlStamp,
  input wire logic [18:0] syncUlRxStamp,
  input wire logic [18:0] syncUlTxStamp,
  output logic syncDlValid,
  output logic [18:0] syncDlStamp,
  output logic syncUlReady
);
  logic [18:0] ctrlCount = 19'h01234;
  logic [18:0] sentStamp = 19'h0;
  logic [18:0] ctrlRxStamp = 19'h0;
  logic [18:0] echoCtrl, echoRx, echoTx;

  initial
  begin
    syncDlValid = 1'b0;
    syncDlStamp = 19'h2aaaa;
    syncUlReady = 1'b0;
  end

  // own frame counter, never phased to the station
  always @(posedge core_clk)
    ctrlCount <= (ctrlCount == 19'h4ffff) ? 19'h0 : ctrlCount + 19'h1;

  ////////////////////////////////////////
  // poke: a second frame while the reply is pending
  task automatic send_sync(input int stall, input bit poke,
                           output logic ok);
    int n;
    ok = 1'b0;
    @(posedge core_clk);
    sentStamp = ctrlCount;
    syncDlValid <= 1'b1;
    syncDlStamp <= ctrlCount;
    @(posedge core_clk);
    syncDlValid <= 1'b0;
    syncDlStamp <= ~sentStamp;
    for (n = 0; n < 8; n++)
    begin
      @(posedge core_clk);
      #1;
      if (syncUlValid === 1'b1)
        break;
    end
    if (n == 8)
      return;
    for (n = 0; n < stall; n++)
    begin
      @(posedge core_clk);
      syncDlValid <= poke && n == 2;
      syncDlStamp <= (poke && n == 2) ? sentStamp ^ 19'h5 : ~sentStamp;
    end
    @(posedge core_clk);
    syncUlReady <= 1'b1;
    @(posedge core_clk);
    echoCtrl = syncUlCtrlStamp;
    echoRx = syncUlRxStamp;
    echoTx = syncUlTxStamp;
    ctrlRxStamp = ctrlCount;
    syncUlReady <= 1'b0;
    ok = 1'b1;
  endtask
endmodule // fat_ctrl_model

/* File: testbench/tb.sv */
// self-checking bench for fat_monitor beside a controller model
// assumes TICK_CHIPS=4: a tick is about 260 clocks, a frame 80 ticks
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [11:0] startMs;
    logic [11:0] endMs;
    logic [18:0] proc;
    int due;
    logic acc;
    logic dis;
    logic adj;
    logic [15:0] off;
  } fat_row_s;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic dataFrameValid = 1'b0;
  logic [18:0] dataFrameDue = 19'h0;
  logic frameAccept, frameDiscard, timingAdjReq, cellFrameStart;
  logic [15:0] arrivalOffset;
  logic syncDlValid, syncUlValid, syncUlReady;
  logic [18:0] syncDlStamp, syncUlCtrlStamp, syncUlRxStamp, syncUlTxStamp;
  logic [11:0] systemFrameNumber, sccpchFrameNumber, sfn0;
  logic [18:0] baseFrameCounter, b;
  logic [31:0] d;
  logic ok;
  int nFail = 0;
  int checkCount = 0;
  int i;
  fat_row_s rows [11];
  logic [11:0] sccOff [4] = '{12'h000, 12'h001, 12'h002, 12'h004};

  always #2 core_clk = ~core_clk;

  fat_monitor #(.TICK_CHIPS(4)) fat_monitor_i (.core_clk(core_clk),
    .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .dataFrameValid(dataFrameValid), .dataFrameDue(dataFrameDue),
    .frameAccept(frameAccept), .frameDiscard(frameDiscard),
    .timingAdjReq(timingAdjReq), .arrivalOffset(arrivalOffset),
    .syncDlValid(syncDlValid), .syncDlStamp(syncDlStamp),
    .syncUlValid(syncUlValid), .syncUlReady(syncUlReady),
    .syncUlCtrlStamp(syncUlCtrlStamp), .syncUlRxStamp(syncUlRxStamp),
    .syncUlTxStamp(syncUlTxStamp), .cellFrameStart(cellFrameStart),
    .systemFrameNumber(systemFrameNumber),
    .sccpchFrameNumber(sccpchFrameNumber),
    .baseFrameCounter(baseFrameCounter));

  fat_ctrl_model fat_ctrl_model_i (.core_clk(core_clk),
    .syncUlValid(syncUlValid), .syncUlCtrlStamp(syncUlCtrlStamp),
    .syncUlRxStamp(syncUlRxStamp), .syncUlTxStamp(syncUlTxStamp),
    .syncDlValid(syncDlValid), .syncDlStamp(syncDlStamp),
    .syncUlReady(syncUlReady));

  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checkCount++;
    if (seen !== exp)
    begin
      nFail++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic give_up(input string what);
    nFail++;
    $display("unexpected at %0t: no %s", $time, what);
    tally_and_finish();
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge core_clk);
    regWr <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    v = regRdata;
  endtask

  // leaves just after a counter step, so it holds for a whole tick
  task automatic wait_tick;
    logic [18:0] last;
    int n;
    last = baseFrameCounter;
    for (n = 0; n < 400; n++)
    begin
      @(posedge core_clk);
      #1;
      if (baseFrameCounter !== last)
      begin
        check(32'(baseFrameCounter), 32'(last + 19'h1), "tick");
        return;
      end
    end
    give_up("counter tick");
  endtask

  task automatic wait_frame;
    int n;
    for (n = 0; n < 22000; n++)
    begin
      @(posedge core_clk);
      #1;
      if (cellFrameStart === 1'b1)
        return;
    end
    give_up("cell frame start");
  endtask

  ////////////////////////////////////////
  initial
  begin
    rows = '{
      '{12'h001, 12'h002, 19'h8, 24, 1, 0, 0, 16'h0000},
      '{12'h001, 12'h002, 19'h8, 32, 1, 0, 0, 16'h0008},
      '{12'h001, 12'h002, 19'h8, 33, 1, 0, 1, 16'h0009},
      '{12'h001, 12'h002, 19'h8, 23, 1, 0, 1, 16'hffff},
      '{12'h001, 12'h002, 19'h8, 8, 1, 0, 1, 16'hfff0},
      '{12'h001, 12'h002, 19'h8, 7, 0, 1, 1, 16'hffef},
      '{12'h4ff, 12'h000, 19'h8, 10240, 1, 0, 0, 16'h27f8},
      '{12'h4ff, 12'h000, 19'h8, 10256, 1, 0, 1, 16'h27ff},
      '{12'h4ff, 12'h514, 19'h8, 8, 1, 0, 1, 16'hd800},
      '{12'h001, 12'h000, 19'h14, 19, 0, 1, 1, 16'hffff},
      '{12'h001, 12'h000, 19'h14, 20, 1, 0, 0, 16'h0000}};
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    for (i = 0; i < 11; i++)
    begin
      reg_wr(fat_pkg::REG_WIN_START, 32'(rows[i].startMs));
      reg_wr(fat_pkg::REG_WIN_END, 32'(rows[i].endMs));
      reg_wr(fat_pkg::REG_PROC_TIME, 32'(rows[i].proc));
      wait_tick();
      b = baseFrameCounter;
      @(posedge core_clk);
      dataFrameValid <= 1'b1;
      dataFrameDue <= 19'(int'(b) + rows[i].due);
      @(posedge core_clk);
      dataFrameValid <= 1'b0;
      dataFrameDue <= ~19'(int'(b) + rows[i].due);
      #1;
      check(32'(frameAccept), 32'(rows[i].acc), "accept");
      check(32'(frameDiscard), 32'(rows[i].dis), "discard");
      check(32'(timingAdjReq), 32'(rows[i].adj), "adjust");
      check(32'(arrivalOffset), 32'(rows[i].off), "offset");
      reg_rd(fat_pkg::REG_ARRIVAL, d);
      check(d, {13'h0, rows[i].dis, rows[i].off[15],
        rows[i].adj & ~rows[i].off[15], rows[i].off}, "arr reg");
      $display("frame row %0d done", i);
    end
    reg_wr(fat_pkg::REG_WIN_START, 32'h0000ffff);
    reg_rd(fat_pkg::REG_WIN_START, d);
    check(d, 32'h000004ff, "start limit");
    reg_wr(fat_pkg::REG_WIN_END, 32'h0000ffff);
    reg_rd(fat_pkg::REG_WIN_END, d);
    check(d, 32'h000009ff, "end limit");
    reg_wr(fat_pkg::REG_CELL_CFG, 32'h0000003f);
    reg_rd(fat_pkg::REG_CELL_CFG, d);
    check(d, 32'h00000039, "cell delay limit");
    reg_wr(8'h40, 32'h00001234);
    reg_rd(8'h40, d);
    check(d, 32'h0, "unmapped");
    $display("limits test done");
    for (i = 0; i < 2; i++)
    begin
      wait_tick();
      b = baseFrameCounter;
      fat_ctrl_model_i.send_sync(300 * i, i[0], ok);
      if (ok !== 1'b1)
        give_up("sync reply");
      check(32'(fat_ctrl_model_i.echoCtrl),
            32'(fat_ctrl_model_i.sentStamp), "echo");
      check(32'(fat_ctrl_model_i.echoRx), 32'(b), "rx stamp");
      check(32'(fat_ctrl_model_i.echoTx), 32'(b + 19'(i)), "tx");
      repeat (4) @(posedge core_clk);
      #1;
      check(32'(syncUlValid), 32'h0, "single reply");
      reg_rd(fat_pkg::REG_TX_STAMP, d);
      check(d, 32'(b + 19'(i)), "tx stamp reg");
      $display("sync test %0d done", i);
    end
    reg_wr(fat_pkg::REG_CELL_CFG, 32'h0);
    wait_frame();
    check(32'(baseFrameCounter % 19'h50), 32'h0, "cell 0");
    sfn0 = systemFrameNumber;
    reg_wr(fat_pkg::REG_CELL_CFG, 32'h1);
    wait_frame();
    check(32'(baseFrameCounter % 19'h50), 32'h40, "cell 1");
    check(32'(systemFrameNumber), 32'(sfn0 + 12'h1), "sfn step");
    for (i = 0; i < 4; i++)
    begin
      reg_wr(fat_pkg::REG_CELL_CFG, 32'(16 * i + 1));
      check(32'(sccpchFrameNumber),
            32'(12'(systemFrameNumber - sccOff[i])), "secondary");
    end
    $display("cell timing test done");
    @(posedge core_clk);
    arst_n <= 1'b0;
    @(posedge core_clk);
    #1;
    check(32'(baseFrameCounter), 32'h0, "counter in reset");
    @(posedge core_clk);
    arst_n <= 1'b1;
    reg_rd(fat_pkg::REG_WIN_START, d);
    check(d, 32'(fat_pkg::WIN_START_RST), "start reset");
    reg_rd(fat_pkg::REG_WIN_END, d);
    check(d, 32'(fat_pkg::WIN_END_RST), "end reset");
    reg_rd(fat_pkg::REG_PROC_TIME, d);
    check(d, 32'(fat_pkg::PROC_TIME_RST), "proc reset");
    $display("reset test done");
    tally_and_finish();
  end
endmodule // tb
